// ==== include/gpc_defs.svh ====
/*
 Holds the offsets, field positions, reset values and timing counts of the
 third pin's control block. Assumes it is included by bare name.
*/
// How it works
// - Bit 15 direction: 0 output, 1 input; resets to input.
// - Bits 14:13 pull: 00 none, 01 down, 10 up, 11 reserved; reset 01.
// - Bit 12 clear: single edge, rising if polarity 1, falling if 0.
// - Bit 12 set: interrupt on both edges regardless of polarity.
// - Bit 11 supply: 0 digital buffer supply, 1 always-on supply; reset 0.
// - Bit 10 polarity: 0 inverts pin sense, 1 non-inverted; reset 1.
// - Bit 9 driver: 0 push-pull, 1 open drain; reset 0.
// - Bit 7 enable: 0 tri-states the pin, 1 normal; reset 0.
// - Bits 3:0 function, reset 0; input 0 debounced, 1 plain input.
// - Input codes 2,3,4: on/off, sleep/wake, debounced sleep/wake request.
// - Input codes 5,6,7: sleep request, power-on request, watchdog reset.
// - Input 8,9 voltage-scale inputs; 10,11 hardware enable inputs.
// - Input 12,13 hardware controls; 14,15 same with long debounce.
// - Output code 0 drives register level; code 1 drives slow clock.
// - Output 2,3,4: ON, SLEEP, state change; 5 to 7 reserved.
// - Output 10,11 drive first and second external power enables.
// - Output 12 system supply good; 13 converter power good.
// - Output 14 drives the external power clock.
// - Output 15 drives the auxiliary reset.
`ifndef GPC_DEFS_SVH
`define GPC_DEFS_SVH
`define GPC_ADDR_CTRL   16'h403A
`define GPC_ADDR_LEVEL  16'h4100
`define GPC_ADDR_STAT   16'h4101
`define GPC_B_DIR       15
`define GPC_B_PULL_HI   14
`define GPC_B_PULL_LO   13
`define GPC_B_BOTH      12
`define GPC_B_DOM       11
`define GPC_B_POL       10
`define GPC_B_OD        9
`define GPC_B_ENA       7
`define GPC_CTRL_RESET  16'hA400
`define GPC_CTRL_MASK   16'hFE8F
`define GPC_DEB_CYCLES  1000
`endif

// ==== include/gpc_pkg.sv ====
/*
 Types of the pin control block. Assumes nothing beyond the header.
*/
package gpc_pkg;
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } gpc_bus_t;

   typedef struct packed {
      logic slow_clk;
      logic on_state;
      logic sleep_state;
      logic state_change;
      logic dvs_done_a;
      logic dvs_done_b;
      logic ext_en_a;
      logic ext_en_b;
      logic system_supply_good;
      logic converter_power_good;
      logic ext_pwr_clk;
      logic aux_reset;
   } gpc_src_t;

   typedef struct packed {
      logic on_off_req;
      logic sleep_wake_req;
      logic sleep_req;
      logic power_on_req;
      logic watchdog_reset;
      logic voltage_scale_input_a;
      logic voltage_scale_input_b;
      logic hw_enable_a;
      logic hw_enable_b;
      logic hw_control_a;
      logic hw_control_b;
      logic gpio_in;
   } gpc_func_t;

   typedef struct packed {
      logic       pad_o;
      logic       pad_oe;
      logic       pull_up;
      logic       pull_down;
      logic       supply_domain;
      logic       irq_event;
   } gpc_pad_t;
endpackage

// ==== src/gpc_pin3.sv ====
/*
 Third general-purpose pin of a power-management device: control register,
 input routing with optional long debounce, output function multiplexing.
 Assumes a single-cycle register port with read data one cycle later and
 that the pad cell resolves pulls and supply from the outputs given.
*/
`timescale 1ns/1ps
`include "gpc_defs.svh"

module gpc_pin3 #(
   parameter int DEB_CYCLES = `GPC_DEB_CYCLES
) (
   // Clock and reset
   input  wire logic               clock,
   input  wire logic               rst_n,
   // Register port
   input  wire gpc_pkg::gpc_bus_t  bus,
   output logic [15:0]             rdata,
   // Internal sources for output functions
   input  wire gpc_pkg::gpc_src_t  src,
   // Pad
   input  wire logic               pad_i,
   output gpc_pkg::gpc_pad_t       pad,
   // Routed input functions
   output gpc_pkg::gpc_func_t      func
);
   import gpc_pkg::*;

   typedef struct packed {
      logic [15:0] ctrl;
      logic        level;
      logic [15:0] rdata;
      logic        sync1;
      logic        sync2;
      logic        raw;
      logic        deb;
      logic [31:0] cnt;
      logic        prev;
      gpc_pad_t    pad;
      gpc_func_t   func;
   } gpc_state_t;

   gpc_state_t s_q;
   gpc_state_t s_d;

   // Long debounce applies to input codes 0, 4, 14 and 15.
   function automatic logic gpc_long_deb(input logic [3:0] fn);
      return (fn == 4'h0) || (fn == 4'h4) || (fn == 4'hE) || (fn == 4'hF);
   endfunction

   function automatic logic gpc_sel(input logic [3:0] fn,
                                    input logic [3:0] code);
      return fn == code;
   endfunction

   logic [3:0] fn;
   logic       is_in;
   logic       sense;
   logic       accepted;
   logic       out_lvl;

   always_comb begin
      s_d = s_q;
      fn = s_q.ctrl[3:0];
      is_in = s_q.ctrl[`GPC_B_DIR];

      if (bus.wr && bus.addr == `GPC_ADDR_CTRL) begin
         s_d.ctrl = bus.wdata & `GPC_CTRL_MASK;
      end
      if (bus.wr && bus.addr == `GPC_ADDR_LEVEL) begin
         s_d.level = bus.wdata[0];
      end
      s_d.rdata = 16'h0000;
      if (bus.rd) begin
         unique case (bus.addr)
            `GPC_ADDR_CTRL:  s_d.rdata = s_q.ctrl;
            `GPC_ADDR_LEVEL: s_d.rdata = {15'h0000, s_q.level};
            `GPC_ADDR_STAT:  s_d.rdata = {14'h0000, s_q.deb, s_q.sync2};
            default:         s_d.rdata = 16'h0000;
         endcase
      end

      s_d.sync1 = pad_i;
      s_d.sync2 = s_q.sync1;
      sense = s_q.ctrl[`GPC_B_POL] ? s_q.sync2 : ~s_q.sync2;
      s_d.raw = sense;

      if (s_q.raw != s_q.deb) begin
         if (s_q.cnt >= 32'(DEB_CYCLES - 1)) begin
            s_d.deb = s_q.raw;
            s_d.cnt = 32'h0000_0000;
         end else begin
            s_d.cnt = s_q.cnt + 32'h0000_0001;
         end
      end else begin
         s_d.cnt = 32'h0000_0000;
      end
      accepted = gpc_long_deb(fn) ? s_q.deb : s_q.raw;

      s_d.prev = accepted;
      s_d.pad.irq_event = (accepted != s_q.prev) &&
         (s_q.ctrl[`GPC_B_BOTH] || accepted);

      s_d.func = '0;
      if (is_in) begin
         s_d.func.gpio_in = (gpc_sel(fn, 4'h0) |
                             gpc_sel(fn, 4'h1)) & accepted;
         s_d.func.on_off_req     = gpc_sel(fn, 4'h2) & accepted;
         s_d.func.sleep_wake_req = (gpc_sel(fn, 4'h3) |
                                    gpc_sel(fn, 4'h4)) & accepted;
         s_d.func.sleep_req      = gpc_sel(fn, 4'h5) & accepted;
         s_d.func.power_on_req   = gpc_sel(fn, 4'h6) & accepted;
         s_d.func.watchdog_reset = gpc_sel(fn, 4'h7) & accepted;
         s_d.func.voltage_scale_input_a = gpc_sel(fn, 4'h8) & accepted;
         s_d.func.voltage_scale_input_b = gpc_sel(fn, 4'h9) & accepted;
         s_d.func.hw_enable_a = gpc_sel(fn, 4'hA) & accepted;
         s_d.func.hw_enable_b = gpc_sel(fn, 4'hB) & accepted;
         s_d.func.hw_control_a = (gpc_sel(fn, 4'hC) |
                                  gpc_sel(fn, 4'hE)) & accepted;
         s_d.func.hw_control_b = (gpc_sel(fn, 4'hD) |
                                  gpc_sel(fn, 4'hF)) & accepted;
      end

      unique case (fn)
         4'h0: out_lvl = s_q.level;
         4'h1: out_lvl = src.slow_clk;
         4'h2: out_lvl = src.on_state;
         4'h3: out_lvl = src.sleep_state;
         4'h4: out_lvl = src.state_change;
         4'h5, 4'h6, 4'h7: out_lvl = 1'b0;
         4'h8: out_lvl = src.dvs_done_a;
         4'h9: out_lvl = src.dvs_done_b;
         4'hA: out_lvl = src.ext_en_a;
         4'hB: out_lvl = src.ext_en_b;
         4'hC: out_lvl = src.system_supply_good;
         4'hD: out_lvl = src.converter_power_good;
         4'hE: out_lvl = src.ext_pwr_clk;
         4'hF: out_lvl = src.aux_reset;
      endcase
      if (s_q.ctrl[`GPC_B_POL] == 1'b0) begin
         out_lvl = ~out_lvl;
      end

      s_d.pad.pad_o = out_lvl;
      s_d.pad.pad_oe = 1'b0;
      if (s_q.ctrl[`GPC_B_OD]) begin
         s_d.pad.pad_o = 1'b0;
      end
      if (s_q.ctrl[`GPC_B_ENA] && !is_in) begin
         if (s_q.ctrl[`GPC_B_OD]) begin
            s_d.pad.pad_oe = ~out_lvl;
         end else begin
            s_d.pad.pad_oe = 1'b1;
         end
      end
      s_d.pad.pull_down = s_q.ctrl[14:13] == 2'b01;
      s_d.pad.pull_up   = s_q.ctrl[14:13] == 2'b10;
      s_d.pad.supply_domain = s_q.ctrl[`GPC_B_DOM];
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.ctrl <= `GPC_CTRL_RESET;
         s_q.pad.pull_down <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata = s_q.rdata;
   assign pad   = s_q.pad;
   assign func  = s_q.func;

   AST_RESET_DIR: assert property (@(posedge clock)
      !rst_n |=> s_q.ctrl[`GPC_B_DIR] && s_q.ctrl[14:13] == 2'b01)
      else $error("control register reset value wrong");
   AST_PULL_UP: assert property (@(posedge clock) disable iff (!rst_n)
      s_q.ctrl[14:13] == 2'b10 |=> pad.pull_up && !pad.pull_down)
      else $error("pull-up not applied");
   AST_SINGLE_EDGE: assert property (@(posedge clock)
      disable iff (!rst_n)
      pad.irq_event && !s_q.ctrl[`GPC_B_BOTH] && $stable(s_q.ctrl)
      |-> s_q.prev)
      else $error("single edge event on wrong edge");
   AST_BOTH_EDGE: assert property (@(posedge clock) disable iff (!rst_n)
      s_q.ctrl[`GPC_B_BOTH] && (accepted != s_q.prev) |=> pad.irq_event)
      else $error("both-edge event missed");
   AST_DOMAIN: assert property (@(posedge clock) disable iff (!rst_n)
      ##1 pad.supply_domain == $past(s_q.ctrl[`GPC_B_DOM]))
      else $error("supply domain does not follow register");
   AST_TRISTATE: assert property (@(posedge clock) disable iff (!rst_n)
      !s_q.ctrl[`GPC_B_ENA] |=> !pad.pad_oe)
      else $error("pin driven while disabled");
   AST_OPEN_DRAIN: assert property (@(posedge clock) disable iff (!rst_n)
      s_q.ctrl[`GPC_B_OD] |=> !pad.pad_o)
      else $error("open drain drove high");
   AST_INPUT_NO_DRIVE: assert property (@(posedge clock)
      disable iff (!rst_n)
      s_q.ctrl[`GPC_B_DIR] |=> !pad.pad_oe)
      else $error("input pin driven");
   AST_DEB_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
      $changed(s_q.deb) |-> $past(s_q.cnt) == 32'(DEB_CYCLES - 1))
      else $error("debounce accepted early");

   // Output mode, push-pull, plain polarity, with the given function code.
   sequence gpc_out_s(logic [3:0] code);
      !s_q.ctrl[`GPC_B_DIR] && !s_q.ctrl[`GPC_B_OD] &&
      s_q.ctrl[`GPC_B_POL] && s_q.ctrl[3:0] == code;
   endsequence

   // Input mode with the given function code.
   sequence gpc_in_s(logic [3:0] code);
      s_q.ctrl[`GPC_B_DIR] && s_q.ctrl[3:0] == code;
   endsequence

   AST_PULL_DOWN: assert property (@(posedge clock)
      disable iff (!rst_n) s_q.ctrl[14:13] == 2'b01
      |=> pad.pull_down && !pad.pull_up)
      else $error("pull-down not applied");
   AST_PULL_NONE: assert property (@(posedge clock)
      disable iff (!rst_n) s_q.ctrl[14] == s_q.ctrl[13]
      |=> !pad.pull_up && !pad.pull_down)
      else $error("pull applied while none selected");
   AST_CMOS_DRIVE: assert property (@(posedge clock)
      disable iff (!rst_n) !s_q.ctrl[`GPC_B_DIR] && s_q.ctrl[`GPC_B_ENA] &&
      !s_q.ctrl[`GPC_B_OD] |=> pad.pad_oe)
      else $error("push-pull output not driven");
   AST_OD_RELEASE: assert property (@(posedge clock)
      disable iff (!rst_n) !s_q.ctrl[`GPC_B_DIR] && s_q.ctrl[`GPC_B_ENA] &&
      s_q.ctrl[`GPC_B_OD] && s_q.ctrl[`GPC_B_POL] && s_q.ctrl[3:0] == 4'h2
      |=> pad.pad_oe == !$past(src.on_state))
      else $error("open drain enable wrong");
   AST_POL_INV: assert property (@(posedge clock)
      disable iff (!rst_n) !s_q.ctrl[`GPC_B_DIR] && !s_q.ctrl[`GPC_B_OD] &&
      !s_q.ctrl[`GPC_B_POL] && s_q.ctrl[3:0] == 4'h2
      |=> pad.pad_o == !$past(src.on_state))
      else $error("inverted output wrong");
   AST_LEVEL_OUT: assert property (@(posedge clock)
      disable iff (!rst_n) gpc_out_s(4'h0)
      |=> pad.pad_o == $past(s_q.level))
      else $error("register level not on pin");
   AST_SLOW_CLK: assert property (@(posedge clock)
      disable iff (!rst_n) gpc_out_s(4'h1)
      |=> pad.pad_o == $past(src.slow_clk))
      else $error("slow clock not on pin");
   AST_ON_STATE: assert property (@(posedge clock)
      disable iff (!rst_n) gpc_out_s(4'h2)
      |=> pad.pad_o == $past(src.on_state))
      else $error("on state not on pin");
   AST_RESERVED_OUT: assert property (@(posedge clock)
      disable iff (!rst_n) gpc_out_s(4'h6)
      |=> !pad.pad_o)
      else $error("reserved output code not inactive");
   AST_DVS_DONE: assert property (@(posedge clock)
      disable iff (!rst_n) gpc_out_s(4'h9)
      |=> pad.pad_o == $past(src.dvs_done_b))
      else $error("scaling done not on pin");
   AST_EXT_ENABLE: assert property (@(posedge clock)
      disable iff (!rst_n) gpc_out_s(4'hA)
      |=> pad.pad_o == $past(src.ext_en_a))
      else $error("external enable not on pin");
   AST_SUPPLY_GOOD: assert property (@(posedge clock)
      disable iff (!rst_n) gpc_out_s(4'hC)
      |=> pad.pad_o == $past(src.system_supply_good))
      else $error("supply good not on pin");
   AST_EXT_CLOCK: assert property (@(posedge clock)
      disable iff (!rst_n) gpc_out_s(4'hE)
      |=> pad.pad_o == $past(src.ext_pwr_clk))
      else $error("external power clock not on pin");
   AST_AUX_RESET: assert property (@(posedge clock)
      disable iff (!rst_n) gpc_out_s(4'hF)
      |=> pad.pad_o == $past(src.aux_reset))
      else $error("auxiliary reset not on pin");
   AST_OUT_NO_ROUTE: assert property (@(posedge clock)
      disable iff (!rst_n) !s_q.ctrl[`GPC_B_DIR]
      |=> func == '0)
      else $error("input function routed in output mode");
   AST_PLAIN_IN: assert property (@(posedge clock)
      disable iff (!rst_n) gpc_in_s(4'h1)
      |=> func.gpio_in == $past(s_q.raw))
      else $error("plain input not routed");
   AST_ONOFF_IN: assert property (@(posedge clock)
      disable iff (!rst_n) gpc_in_s(4'h2)
      |=> func.on_off_req == $past(s_q.raw))
      else $error("on/off request not routed");
   AST_WDOG_IN: assert property (@(posedge clock)
      disable iff (!rst_n) gpc_in_s(4'h7)
      |=> func.watchdog_reset == $past(s_q.raw))
      else $error("watchdog input not routed");
   AST_SCALE_IN: assert property (@(posedge clock)
      disable iff (!rst_n) gpc_in_s(4'h8)
      |=> func.voltage_scale_input_a == $past(s_q.raw))
      else $error("scaling input not routed");
   AST_HWC_DEB: assert property (@(posedge clock)
      disable iff (!rst_n) gpc_in_s(4'hE)
      |=> func.hw_control_a == $past(s_q.deb))
      else $error("debounced control input not routed");
   AST_IRQ_CAUSE: assert property (@(posedge clock)
      disable iff (!rst_n) pad.irq_event
      |-> $past(accepted) != $past(s_q.prev))
      else $error("pin event without level change");
endmodule

// ==== tb/gpc_ext_model.sv ====
/*
 External logic on the third pin: drives the line or releases it.
 Assumes the pad outputs of the pin block and a drive request from the bench.
*/
`timescale 1ns/1ps
module gpc_ext_model (
   // Clock
   input  wire logic              clock,
   // Pin side
   input  wire gpc_pkg::gpc_pad_t pad,
   input  wire logic              ext_en,
   input  wire logic              ext_val,
   output logic                   pad_i
);
   import gpc_pkg::*;
   logic float_q = 1'b0;
   // An undriven line without pull wanders every cycle.
   always @(posedge clock) float_q <= ~float_q;
   always_comb begin
      if (pad.pad_oe) pad_i = pad.pad_o;
      else if (ext_en) pad_i = ext_val;
      else if (pad.pull_up) pad_i = 1'b1;
      else if (pad.pull_down) pad_i = 1'b0;
      else pad_i = float_q;
   end
endmodule

// ==== tb/gpc_pin3_tb_top.sv ====
/*
 Self-checking bench of the third pin block: registers, output functions,
 input routing, debounce and pin events. Assumes the package and header.
*/
`timescale 1ns/1ps
`include "gpc_defs.svh"
module gpc_pin3_tb_top;
   import gpc_pkg::*;
   logic clock = 1'b0, rst_n = 1'b0, ext_en = 1'b1, ext_val = 1'b0;
   logic pad_i, rd_dly = 1'b0, pl, lv;
   gpc_bus_t bus = '0;
   gpc_src_t src = '0;
   gpc_pad_t pad;
   gpc_func_t func;
   logic [15:0] rdata, exq[$];
   int fail_count = 0, checked = 0, irq_n = 0, n0, seed = 8421;
   int isel[16] = '{0,0,11,10,10,9,8,7,6,5,4,3,2,1,2,1};
   int osel[16] = '{0,11,10,9,8,0,0,0,7,6,5,4,3,2,1,0};
   always #5 clock = ~clock;
   gpc_pin3 #(.DEB_CYCLES(4)) dut (.clock(clock), .rst_n(rst_n),
      .bus(bus), .rdata(rdata), .src(src), .pad_i(pad_i), .pad(pad),
      .func(func));
   gpc_ext_model peer (.clock(clock), .pad(pad), .ext_en(ext_en),
      .ext_val(ext_val), .pad_i(pad_i));
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      checked++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         fail_count++;
      end
   endtask
   task automatic end_sim();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(logic [15:0] a, logic [15:0] d);
      @(posedge clock);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clock);
      bus.wr <= 1'b0;
      repeat (12) @(posedge clock);
   endtask
   task automatic rd(logic [15:0] a, logic [15:0] e);
      @(posedge clock);
      bus <= '{a, 16'h0000, 1'b0, 1'b1};
      exq.push_back(e);
      @(posedge clock);
      bus.rd <= 1'b0;
   endtask
   task automatic pin(logic v);
      ext_val <= v;
      repeat (14) @(posedge clock);
   endtask
   // Read data are compared in the one cycle where they stand.
   always @(posedge clock) begin
      rd_dly <= bus.rd;
      if (rd_dly) chk("rdata", exq.pop_front(), rdata);
      if (pad.irq_event === 1'b1) irq_n++;
   end
   initial begin
      #100us;
      fail_count++;
      end_sim();
   end
   initial begin
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      rd(`GPC_ADDR_CTRL, 16'hA400);
      chk("pull_down", 16'h0001, {15'h0000, pad.pull_down});
      chk("pad_oe", 16'h0000, {15'h0000, pad.pad_oe});
      rd(16'h4102, 16'h0000);
      wr(`GPC_ADDR_CTRL, 16'hFFFF);
      rd(`GPC_ADDR_CTRL, `GPC_CTRL_MASK);
      wr(`GPC_ADDR_CTRL, 16'hCC80); // pull-up, always-on supply
      chk("pull", 16'h8081, {pad.pull_up, 3'h0, pad.pull_down,
         3'h0, pad.supply_domain, 3'h0, 4'h1});
      // Output functions with random internal sources.
      wr(`GPC_ADDR_LEVEL, 16'h0001);
      rd(`GPC_ADDR_LEVEL, 16'h0001);
      for (int i = 0; i < 19; i++) begin
         n0 = (i < 16) ? i : 2;
         pl = (i != 16);
         src <= gpc_src_t'(12'($random(seed)));
         wr(`GPC_ADDR_CTRL, {5'h00, pl, i == 17, 1'b0, i != 18, 3'h0,
            4'(n0)});
         lv = (n0 == 0) ? 1'b1 : (n0 > 4 && n0 < 8) ? 1'b0 : src[osel[n0]];
         if (i == 17) begin
            chk("od_oe", {15'h0000, ~lv}, {15'h0000, pad.pad_oe});
            chk("od_o", 16'h0000, {15'h0000, pad.pad_o});
         end else if (i == 18) begin
            chk("tri", 16'h0000, {15'h0000, pad.pad_oe});
         end else begin
            chk("pad_o", {15'h0001, pl ? lv : ~lv},
               {14'h0000, pad.pad_oe, pad.pad_o});
         end
      end
      // Input routing of every code.
      for (int c = 0; c < 16; c++) begin
         wr(`GPC_ADDR_CTRL, 16'hA480 | 16'(c));
         pin(1'b1);
         chk("func", 16'(1 << isel[c]),
            {4'h0, func});
         if (c == 0) rd(`GPC_ADDR_STAT, 16'h0003);
         pin(1'b0);
      end
      // A short glitch is rejected by the long debounce.
      wr(`GPC_ADDR_CTRL, 16'hA480);
      ext_val <= 1'b1;
      repeat (2) @(posedge clock);
      ext_val <= 1'b0;
      repeat (4) @(posedge clock);
      chk("glitch", 16'h0000, {4'h0, func});
      pin(1'b0);
      // Edge events: single rising, both edges, single inverted.
      for (int m = 0; m < 3; m++) begin
         wr(`GPC_ADDR_CTRL, (m == 2) ? 16'hA081 :
            (m == 1) ? 16'hB481 : 16'hA481);
         pin(m == 2);
         n0 = irq_n;
         pin(m != 2);
         pin(m == 2);
         chk("irq", 16'((m == 1) ? 2 : 1), 16'(irq_n - n0));
      end
      repeat (4) @(posedge clock);
      end_sim();
   end
endmodule
